// file: src/ipw_params.svh
// Offsets, field positions, reset values and timing counts of the interrupt pulse block.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
`ifndef IPW_PARAMS_SVH
`define IPW_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define IPW_OFF_MAIN_STAT 12'h000
`define IPW_OFF_MAIN_CLR 12'h004
`define IPW_OFF_MAIN_MASK 12'h008
`define IPW_OFF_FS_STAT 12'h00c
`define IPW_OFF_FS_CLR 12'h010
`define IPW_OFF_FS_MASK 12'h014
`define IPW_OFF_CTRL 12'h018
`define IPW_OFF_WAKE 12'h01c
`define IPW_OFF_IRQ_STAT 12'h020
`define IPW_OFF_IRQ_CLR 12'h024
`define IPW_OFF_IRQ_EN 12'h028

// ==========================================================================
// Field positions
`define IPW_CTRL_STANDBY 0
`define IPW_WAKE_ONE 0
`define IPW_WAKE_TWO 1
`define IPW_WAKE_BIAS 2
`define IPW_WAKE_PULSE 3
`define IPW_EV_PULSE 0
`define IPW_EV_WAKE 1
`define IPW_EV_BIAS_OFF 2

// ==========================================================================
// Reset values
`define IPW_MAIN_MASK_RST 23'h000000
`define IPW_FS_MASK_RST 12'h000

// ==========================================================================
// Timing, clock rate in kHz, times in ns
`define IPW_CLK_KHZ 40000
`define IPW_PULSE_NS 100000
`define IPW_FILT_NS 70000
// Scaled in steps so the product stays inside a 32-bit integer
`define IPW_PULSE_CYC (((`IPW_PULSE_NS / 1000) * `IPW_CLK_KHZ) / 1000)
`define IPW_FILT_CYC (((`IPW_FILT_NS / 1000) * `IPW_CLK_KHZ) / 1000)

`endif

// file: src/ipw_pkg.sv
// Types shared by the interrupt pulse and wake input block.
// Assumes nothing of its surroundings.
package ipw_pkg;
  typedef enum logic [1:0] {
    IPW_IDLE,
    IPW_PULSE
  } ipw_state_e;
endpackage

// file: src/ipw_irq_wake.sv
// Interrupt aggregation, open-drain pulse output and wake input filtering.
// Assumes event inputs are one-cycle pulses synchronous to clk, and wake levels are
// already compared against the digital and analog thresholds outside.
`timescale 1ns/1ps
`include "ipw_params.svh"

// Behaviour
// - An unmasked event drives the interrupt pin low for one pulse, otherwise it is released.
// - The low pulse lasts 100 us nominal, within 90 to 110 us.
// - Every source has its own inhibit bit that suppresses its pulse.
// - Main sources are supply 7 V, high and low, backup high, both wake transitions, bus error.
// - Regulator events: pre-regulator overcurrent and voltage, step-downs and linears thermal and overcurrent, step-up thermal and voltage.
// - Fail-safe sources are fault pair, two fault inputs, error monitor and rail monitors.
// - Watchdog wrong data and wrong timing are two separate interrupts.
// - Wake inputs are level based: above high gives one, below low gives zero.
// - Each wake input is filtered for 70 us before its state changes.
// - Either wake input above the high threshold starts internal biasing.
// - Both wake inputs below the analog low threshold stop biasing only in Standby.
module ipw_irq_wake #(
  parameter int PULSE_CYC = `IPW_PULSE_CYC,
  parameter int FILT_CYC = `IPW_FILT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_under_seven_volt,
  input wire logic supply_under_high,
  input wire logic supply_under_low,
  input wire logic backup_supply_under_high,
  input wire logic prereg_overcurrent,
  input wire logic prereg_overvoltage,
  input wire logic prereg_under_high,
  input wire logic stepdown_one_thermal,
  input wire logic stepdown_one_overcurrent,
  input wire logic stepdown_two_thermal,
  input wire logic stepdown_two_overcurrent,
  input wire logic stepdown_three_thermal,
  input wire logic stepdown_three_overcurrent,
  input wire logic stepup_thermal,
  input wire logic stepup_overvoltage,
  input wire logic stepup_under_high,
  input wire logic linear_one_thermal,
  input wire logic linear_one_overcurrent,
  input wire logic linear_two_thermal,
  input wire logic linear_two_overcurrent,
  input wire logic bus_comm_error,
  input wire logic fault_pair_bistable_error,
  input wire logic fault_input_one_error,
  input wire logic fault_input_two_error,
  input wire logic external_error_monitor,
  input wire logic core_rail_overvoltage,
  input wire logic core_rail_undervoltage,
  input wire logic io_supply_overvoltage,
  input wire logic io_supply_undervoltage,
  input wire logic voltage_monitor_overvoltage,
  input wire logic voltage_monitor_undervoltage,
  input wire logic watchdog_wrong_data,
  input wire logic watchdog_wrong_timing,
  input wire logic wake_one_above_high,
  input wire logic wake_one_below_low,
  input wire logic wake_one_below_analog,
  input wire logic wake_two_above_high,
  input wire logic wake_two_below_low,
  input wire logic wake_two_below_analog,
  output logic irq_out_n_o,
  output logic irq_out_n_oe,
  output logic wake_input_one,
  output logic wake_input_two,
  output logic bias_on,
  output logic irq
);

  // ==========================================================================
  // State
  typedef struct packed {
    ipw_pkg::ipw_state_e st;
    logic [15:0] pcnt;
    logic [15:0] fcnt1;
    logic [15:0] fcnt2;
    logic wk1;
    logic wk2;
    logic bias;
    logic [22:0] mstat;
    logic [22:0] mmask;
    logic [11:0] fstat;
    logic [11:0] fmask;
    logic standby;
    logic [2:0] istat;
    logic [2:0] ien;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic pin_oe;
    logic irq;
  } ipw_regs_s;

  ipw_regs_s q_r;
  ipw_regs_s q_nxt;

  // Filter one wake input: state follows a valid level only after it stands FILT_CYC cycles
  function automatic logic [16:0] wake_filt(input logic st, input logic hi, input logic lo,
                                            input logic [15:0] cnt);
    logic want;
    logic valid;
    want = hi;
    valid = (hi && !st) || (lo && st);
    if (!valid) begin
      wake_filt = {st, 16'h0000};
    end else if (cnt >= 16'(FILT_CYC - 1)) begin
      wake_filt = {want, 16'h0000};
    end else begin
      wake_filt = {st, 16'(cnt + 16'h0001)};
    end
  endfunction

  logic [22:0] main_ev;
  logic [11:0] fs_ev;
  logic wk1_tr;
  logic wk2_tr;
  logic [16:0] f1;
  logic [16:0] f2;
  logic wr;
  logic rd;

  // ==========================================================================
  // Next state
  always_comb begin
    q_nxt = q_r;
    f1 = wake_filt(q_r.wk1, wake_one_above_high, wake_one_below_low, q_r.fcnt1);
    f2 = wake_filt(q_r.wk2, wake_two_above_high, wake_two_below_low, q_r.fcnt2);
    q_nxt.wk1 = f1[16];
    q_nxt.fcnt1 = f1[15:0];
    q_nxt.wk2 = f2[16];
    q_nxt.fcnt2 = f2[15:0];
    wk1_tr = f1[16] != q_r.wk1;
    wk2_tr = f2[16] != q_r.wk2;
    main_ev = {bus_comm_error, wk2_tr, wk1_tr, linear_two_overcurrent, linear_two_thermal,
               linear_one_overcurrent, linear_one_thermal, stepup_under_high,
               stepup_overvoltage, stepup_thermal, stepdown_three_overcurrent,
               stepdown_three_thermal, stepdown_two_overcurrent, stepdown_two_thermal,
               stepdown_one_overcurrent, stepdown_one_thermal, prereg_under_high,
               prereg_overvoltage, prereg_overcurrent, backup_supply_under_high,
               supply_under_low, supply_under_high, supply_under_seven_volt};
    fs_ev = {watchdog_wrong_timing, watchdog_wrong_data, voltage_monitor_undervoltage,
             voltage_monitor_overvoltage, io_supply_undervoltage, io_supply_overvoltage,
             core_rail_undervoltage, core_rail_overvoltage, external_error_monitor,
             fault_input_two_error, fault_input_one_error, fault_pair_bistable_error};

    // APB access, one wait state
    wr = psel && penable && pwrite && !q_r.ready;
    rd = psel && penable && !pwrite && !q_r.ready;
    q_nxt.ready = psel && penable && !q_r.ready;
    q_nxt.err = 1'b0;
    q_nxt.rdata = 32'h0000_0000;
    if (wr) begin
      case (paddr)
        `IPW_OFF_MAIN_CLR: q_nxt.mstat = q_r.mstat & ~pwdata[22:0];
        `IPW_OFF_MAIN_MASK: q_nxt.mmask = pwdata[22:0];
        `IPW_OFF_FS_CLR: q_nxt.fstat = q_r.fstat & ~pwdata[11:0];
        `IPW_OFF_FS_MASK: q_nxt.fmask = pwdata[11:0];
        `IPW_OFF_CTRL: q_nxt.standby = pwdata[`IPW_CTRL_STANDBY];
        `IPW_OFF_IRQ_CLR: q_nxt.istat = q_r.istat & ~pwdata[2:0];
        `IPW_OFF_IRQ_EN: q_nxt.ien = pwdata[2:0];
        default: q_nxt.err = 1'b1;
      endcase
    end
    if (rd) begin
      case (paddr)
        `IPW_OFF_MAIN_STAT: q_nxt.rdata = {9'h000, q_r.mstat};
        `IPW_OFF_MAIN_MASK: q_nxt.rdata = {9'h000, q_r.mmask};
        `IPW_OFF_FS_STAT: q_nxt.rdata = {20'h00000, q_r.fstat};
        `IPW_OFF_FS_MASK: q_nxt.rdata = {20'h00000, q_r.fmask};
        `IPW_OFF_CTRL: q_nxt.rdata = {31'h0, q_r.standby};
        `IPW_OFF_WAKE: q_nxt.rdata = {28'h0, q_r.pin_oe, q_r.bias, q_r.wk2, q_r.wk1};
        `IPW_OFF_IRQ_STAT: q_nxt.rdata = {29'h0, q_r.istat};
        `IPW_OFF_IRQ_EN: q_nxt.rdata = {29'h0, q_r.ien};
        default: q_nxt.err = 1'b1;
      endcase
    end

    // Bias control, after the clear so a same-cycle bias-off event wins
    if ((wake_one_above_high || wake_two_above_high) && !q_r.bias) begin
      q_nxt.bias = 1'b1;
    end else if (wake_one_below_analog && wake_two_below_analog && q_r.standby && q_r.bias) begin
      q_nxt.bias = 1'b0;
      q_nxt.istat[`IPW_EV_BIAS_OFF] = 1'b1;
    end

    // Sources latch after any clear so a same-cycle event wins
    q_nxt.mstat = q_nxt.mstat | main_ev;
    q_nxt.fstat = q_nxt.fstat | fs_ev;
    if (wk1_tr || wk2_tr) begin
      q_nxt.istat[`IPW_EV_WAKE] = 1'b1;
    end

    // Pulse generator, counts raw oscillator cycles
    case (q_r.st)
      ipw_pkg::IPW_IDLE: begin
        if (|(main_ev & ~q_r.mmask) || |(fs_ev & ~q_r.fmask)) begin
          q_nxt.st = ipw_pkg::IPW_PULSE;
          q_nxt.pin_oe = 1'b1;
          q_nxt.pcnt = 16'h0000;
          q_nxt.istat[`IPW_EV_PULSE] = 1'b1;
        end
      end
      ipw_pkg::IPW_PULSE: begin
        if (q_r.pcnt >= 16'(PULSE_CYC - 1)) begin
          q_nxt.st = ipw_pkg::IPW_IDLE;
          q_nxt.pin_oe = 1'b0;
        end else begin
          q_nxt.pcnt = q_r.pcnt + 16'h0001;
        end
      end
      default: begin
        q_nxt.st = ipw_pkg::IPW_IDLE;
        q_nxt.pin_oe = 1'b0;
      end
    endcase
    q_nxt.irq = |(q_nxt.istat & q_nxt.ien);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
      q_r.st <= ipw_pkg::IPW_IDLE;
      q_r.mmask <= `IPW_MAIN_MASK_RST;
      q_r.fmask <= `IPW_FS_MASK_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prdata = q_r.rdata;
  assign pready = q_r.ready;
  assign pslverr = q_r.err;
  assign irq_out_n_o = 1'b0;
  assign irq_out_n_oe = q_r.pin_oe;
  assign wake_input_one = q_r.wk1;
  assign wake_input_two = q_r.wk2;
  assign bias_on = q_r.bias;
  assign irq = q_r.irq;

endmodule

// file: bench/ipw_irq_wake_monitor.sv
// Checker for the interrupt pulse and wake block, bound to every instance.
// Assumes one APB wait state and a low pulse of PULSE_CYC cycles.
`timescale 1ns/1ps
module ipw_irq_wake_monitor #(
  parameter int PULSE_CYC = 4000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_out_n_o,
  input wire logic irq_out_n_oe,
  input wire logic wake_one_above_high,
  input wire logic wake_two_above_high,
  input wire logic wake_one_below_analog,
  input wire logic wake_two_below_analog,
  input wire logic bias_on
);
  int pcnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Length of the current low pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) pcnt <= 0;
    else pcnt <= irq_out_n_oe ? pcnt + 1 : 0;
  end
  pulse_len_a: assert property ($fell(irq_out_n_oe) |-> pcnt == PULSE_CYC)
    else $error("pulse length differs");
  pulse_max_a: assert property (irq_out_n_oe |-> pcnt < PULSE_CYC)
    else $error("pulse too long");
  pin_low_a: assert property (irq_out_n_oe |-> !irq_out_n_o)
    else $error("pin driven high");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait");
  apb_one_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  bias_start_a: assert property (wake_one_above_high || wake_two_above_high |=> bias_on)
    else $error("bias not started");
  bias_stop_a: assert property ($fell(bias_on) |->
    $past(wake_one_below_analog) && $past(wake_two_below_analog))
    else $error("bias stopped early");
endmodule

bind ipw_irq_wake ipw_irq_wake_monitor #(.PULSE_CYC(PULSE_CYC)) i_mon (.*);

// file: bench/ipw_host_model.sv
// Host side model counting and timing low pulses on the interrupt pin.
// Assumes the pin has a pull-up, so a released pin reads high.
`timescale 1ns/1ps
module ipw_host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic irq_out_n_o,
  input wire logic irq_out_n_oe,
  output int n_pulses,
  output int last_len
);
  int run;
  wire pin = irq_out_n_oe ? irq_out_n_o : 1'b1;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run <= 0;
      n_pulses <= 0;
      last_len <= 0;
    end else if (!pin) run <= run + 1;
    else if (run != 0) begin
      n_pulses <= n_pulses + 1;
      last_len <= run;
      run <= 0;
    end
  end
endmodule

// file: bench/ipw_irq_wake_tb.sv
// Self-checking bench for the interrupt pulse and wake block.
// Assumes the block, its checker and the host model are compiled beside it.
`timescale 1ns/1ps
`include "ipw_params.svh"
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module ipw_irq_wake_tb;
  localparam int PC = 20;
  localparam int FC = 10;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic irq_out_n_o, irq_out_n_oe, wake_input_one, wake_input_two, bias_on, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [22:0] mev = '0;
  logic [11:0] fev = '0;
  logic [5:0] wk = '0;
  int miscompares = 0, num_checks = 0, cyc = 0, np, ll, n0;
  wire supply_under_seven_volt = mev[0], supply_under_high = mev[1], supply_under_low = mev[2];
  wire backup_supply_under_high = mev[3], prereg_overcurrent = mev[4];
  wire prereg_overvoltage = mev[5], prereg_under_high = mev[6], stepdown_one_thermal = mev[7];
  wire stepdown_one_overcurrent = mev[8], stepdown_two_thermal = mev[9];
  wire stepdown_two_overcurrent = mev[10], stepdown_three_thermal = mev[11];
  wire stepdown_three_overcurrent = mev[12], stepup_thermal = mev[13];
  wire stepup_overvoltage = mev[14], stepup_under_high = mev[15], linear_one_thermal = mev[16];
  wire linear_one_overcurrent = mev[17], linear_two_thermal = mev[18];
  wire linear_two_overcurrent = mev[19], bus_comm_error = mev[22];
  wire fault_pair_bistable_error = fev[0], fault_input_one_error = fev[1];
  wire fault_input_two_error = fev[2], external_error_monitor = fev[3];
  wire core_rail_overvoltage = fev[4], core_rail_undervoltage = fev[5];
  wire io_supply_overvoltage = fev[6], io_supply_undervoltage = fev[7];
  wire voltage_monitor_overvoltage = fev[8], voltage_monitor_undervoltage = fev[9];
  wire watchdog_wrong_data = fev[10], watchdog_wrong_timing = fev[11];
  wire wake_one_above_high = wk[0], wake_one_below_low = wk[1], wake_one_below_analog = wk[2];
  wire wake_two_above_high = wk[3], wake_two_below_low = wk[4], wake_two_below_analog = wk[5];
  ipw_irq_wake #(.PULSE_CYC(PC), .FILT_CYC(FC)) i_dut (.*);
  ipw_host_model i_host (.clk(clk), .rst_b(rst_b), .irq_out_n_o(irq_out_n_o),
    .irq_out_n_oe(irq_out_n_oe), .n_pulses(np), .last_len(ll));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      miscompares++;
      close_out();
    end
  end
  task close_out();
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Event on source j, a second one during the pulse, with or without its inhibit bit
  task automatic fire(int j, bit inh);
    int b;
    logic [11:0] st;
    logic [31:0] m;
    b = j < 23 ? j : j - 23;
    st = j < 23 ? `IPW_OFF_MAIN_STAT : `IPW_OFF_FS_STAT;
    m = inh ? $urandom() | (32'h1 << b) : $urandom() & ~(32'h1 << b);
    apb(1, st + 12'h008, m);
    apb(1, st + 12'h004, '1);
    n0 = np;
    for (int k = 0; k < 2; k++) begin
      repeat (3) @(posedge clk);
      if (j < 23) mev[b] <= 1;
      else fev[b] <= 1;
      @(posedge clk);
      mev <= '0;
      fev <= '0;
    end
    repeat (PC + 5) @(posedge clk);
    `CK("pulses", n0 + (inh ? 0 : 1), np)
    if (!inh) begin
      `CK("pulse len", PC, ll)
      apb(0, st, 0);
      `CK("status", 32'h1 << b, rd)
    end
  endtask
  task automatic wake(logic [5:0] v, int n);
    wk <= v;
    repeat (n) @(posedge clk);
  endtask
  initial begin
    void'($urandom(6035));
    repeat (20) @(posedge clk);
    rst_b <= 1;
    apb(0, `IPW_OFF_MAIN_MASK, 0);
    `CK("main mask", 32'h0, rd)
    apb(0, `IPW_OFF_FS_MASK, 0);
    `CK("fs mask", 32'h0, rd)
    apb(0, 12'h040, 0);
    `CK("unmapped", 1'b1, er)
    apb(1, `IPW_OFF_MAIN_STAT, '1);
    `CK("read only", 1'b1, er)
    apb(1, `IPW_OFF_IRQ_EN, 32'h1);
    for (int j = 0; j < 35; j++) if (j != 20 && j != 21) begin
      fire(j, 1);
      fire(j, 0);
    end
    `CK("irq raised", 1'b1, irq)
    apb(1, `IPW_OFF_IRQ_EN, 0);
    repeat (2) @(posedge clk);
    `CK("irq masked", 1'b0, irq)
    apb(1, `IPW_OFF_IRQ_EN, 32'h1);
    apb(1, `IPW_OFF_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    `CK("irq cleared", 1'b0, irq)
    apb(1, `IPW_OFF_MAIN_MASK, 0);
    apb(1, `IPW_OFF_MAIN_CLR, '1);
    apb(1, `IPW_OFF_CTRL, 32'h1);
    wake(6'h01, FC - 3);
    wake(6'h00, 2);
    `CK("filtered", 1'b0, wake_input_one)
    `CK("bias on", 1'b1, bias_on)
    wake(6'h01, FC + 3);
    `CK("wake one", 1'b1, wake_input_one)
    wake(6'h36, FC + 3);
    `CK("wake low", 1'b0, wake_input_one)
    `CK("bias off", 1'b0, bias_on)
    apb(0, `IPW_OFF_IRQ_STAT, 0);
    `CK("bias off flag", 32'h4, rd & 32'h4)
    apb(0, `IPW_OFF_MAIN_STAT, 0);
    `CK("wake event", 32'h100000, rd)
    apb(1, `IPW_OFF_CTRL, 0);
    wake(6'h08, FC + 3);
    `CK("wake two", 1'b1, wake_input_two)
    wake(6'h36, FC + PC + 3);
    apb(0, `IPW_OFF_WAKE, 0);
    `CK("bias kept", 32'h4, rd)
    close_out();
  end
endmodule
